/* src/sri_pkg.sv */
// constants for the serial register interface
package sri_pkg;
  localparam int SRI_AW = 2;
  // register offsets
  localparam logic [1:0] SRI_OFS_CTRL = 2'h0;
  localparam logic [1:0] SRI_OFS_STAT = 2'h1;
  localparam logic [1:0] SRI_OFS_DATA = 2'h2;
  localparam logic [1:0] SRI_OFS_DIR = 2'h3;
  // control fields
  localparam int SRI_C_IRQ_EN = 7;
  localparam int SRI_C_ENABLE = 6;
  localparam int SRI_C_OPEN_DRAIN = 5;
  localparam int SRI_C_MASTER = 4;
  localparam int SRI_C_CLOCK_POLARITY = 3;
  localparam int SRI_C_CLOCK_PHASE = 2;
  localparam int SRI_C_RATE_HI = 1;
  localparam int SRI_C_RATE_LO = 0;
  localparam logic [7:0] SRI_CTRL_RESET = 8'h04;
  // status fields
  localparam int SRI_S_TC = 7;
  localparam int SRI_S_WRITE_COLLISION_FLAG = 6;
  localparam int SRI_S_MODE_FAULT_FLAG = 4;
  // direction fields
  localparam int SRI_D_MISO = 0;
  localparam int SRI_D_MOSI = 1;
  localparam int SRI_D_SCK = 2;
  localparam int SRI_D_SS = 3;
  localparam logic [3:0] SRI_DIR_RESET = 4'h0;
  // half serial clock periods in clock cycles, per rate code
  localparam logic [4:0] SRI_HALF_DIV2 = 5'h01;
  localparam logic [4:0] SRI_HALF_DIV4 = 5'h02;
  localparam logic [4:0] SRI_HALF_DIV16 = 5'h08;
  localparam logic [4:0] SRI_HALF_DIV32 = 5'h10;
  // sixteen serial clock edges per byte
  localparam logic [4:0] SRI_EDGES = 5'h10;
  typedef enum logic {SRI_IDLE, SRI_XFER} sri_state_type;
endpackage : sri_pkg

/* src/sri_clk_div.sv */
// serial clock half-period tick generator
`timescale 1ns/1ps
`default_nettype none
module sri_clk_div
  import sri_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic restart,
  input wire logic [1:0] rate,
  output logic tick
);
  logic [4:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  logic [4:0] half;

  always_comb begin
    unique case (rate)
      2'b00: half = SRI_HALF_DIV2;
      2'b01: half = SRI_HALF_DIV4;
      2'b10: half = SRI_HALF_DIV16;
      2'b11: half = SRI_HALF_DIV32;
    endcase
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (restart || !run) begin
      cnt_d = 5'h00; // R22
    end else if (cnt_q == half - 5'h01) begin
      cnt_d = 5'h00;
      tick_d = 1'b1; // R6
    end else begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : sri_clk_div
`default_nettype wire

/* src/sri_core.sv */
// byte-wide serial peripheral interface with control, status and data registers
//
// Overview of operation
// R1 - enable bit switches interface off or on
// R2 - open-drain bit affects all shared pins
// R3 - master select bit: slave or master
// R4 - master clock idles at polarity level
// R5 - phase with polarity picks clocking protocol
// R6 - rate bits divide clock 2,4,16,32
// R7 - slave ignores rate, uses remote clock
// R8 - complete flag set after each byte
// R9 - interrupt while complete flag and enable
// R10 - complete clears: status read, data access
// R11 - data writes blocked until status read
// R12 - collision clears: status read, data access
// R13 - fault clears: status read, control write
// R14 - unused status bits read zero
// R15 - only master data write starts transfer
// R16 - data reads return receive buffer
// R17 - software clears flag before next byte
// R18 - select low on master: fault, drop drivers
// R19 - busy data write sets collision, ignored
// R20 - eight clocks exchange one byte each way
// R21 - select high between bytes in phase 0
// R22 - divider restarts at each master transfer
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sri_core
  import sri_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [SRI_AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n_in
);
  import sri_pkg::*;

  logic [7:0] ctrl_q, ctrl_d;
  logic [3:0] dir_q, dir_d;
  logic tc_q, tc_d, write_collision_flag_q, write_collision_flag_d, mode_fault_flag_q, mode_fault_flag_d;
  logic arm_tc_q, arm_tc_d, arm_write_collision_flag_q, arm_write_collision_flag_d, arm_mode_fault_flag_q, arm_mode_fault_flag_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  sri_state_type state_q, state_d;
  logic [7:0] sh_q, sh_d, rxbuf_q, rxbuf_d;
  logic [4:0] edge_q, edge_d;
  logic smp_q, smp_d, out_q, out_d, sck_q, sck_d, sck_prev_q;
  logic sck_out_q, sck_oe_q, mosi_out_q, mosi_oe_q, miso_out_q, miso_oe_q;
  logic sck_out_d, sck_oe_d, mosi_out_d, mosi_oe_d, miso_out_d, miso_oe_d;
  logic en, mst, clock_polarity, clock_phase, od, tick, restart;
  logic slave_act, slave_edge, edge_ev, leading, sample_ev, drive_ev, done, busy;
  logic ctrl_wr, stat_rd, data_wr, data_rd, data_acc, wr_ok, start, fault;
  logic din;
  logic [7:0] stat_val;

  assign en = ctrl_q[SRI_C_ENABLE];
  assign mst = ctrl_q[SRI_C_MASTER]; // R3
  assign clock_polarity = ctrl_q[SRI_C_CLOCK_POLARITY];
  assign clock_phase = ctrl_q[SRI_C_CLOCK_PHASE];
  assign od = ctrl_q[SRI_C_OPEN_DRAIN];

  assign ctrl_wr = wr && addr == SRI_OFS_CTRL;
  assign stat_rd = rd && addr == SRI_OFS_STAT;
  assign data_wr = wr && addr == SRI_OFS_DATA;
  assign data_rd = rd && addr == SRI_OFS_DATA;
  assign data_acc = data_wr || data_rd;

  // status image, unused bits zero
  always_comb begin
    stat_val = 8'h00; // R14
    stat_val[SRI_S_TC] = tc_q;
    stat_val[SRI_S_WRITE_COLLISION_FLAG] = write_collision_flag_q;
    stat_val[SRI_S_MODE_FAULT_FLAG] = mode_fault_flag_q;
  end

  sri_clk_div u_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(state_q == SRI_XFER),
    .restart(restart),
    .rate(ctrl_q[SRI_C_RATE_HI:SRI_C_RATE_LO]),
    .tick(tick)
  );

  // transfer engine
  always_comb begin
    slave_act = en && !mst && !ss_n_in;
    // slave edges come from the remote clock only
    slave_edge = slave_act && (sck_in != sck_prev_q); // R7
    edge_ev = (state_q == SRI_XFER) ? tick : slave_edge;
    leading = !edge_q[0];
    sample_ev = edge_ev && (leading ^ clock_phase); // R5
    drive_ev = edge_ev && !(leading ^ clock_phase); // R5
    din = mst ? miso_in : mosi_in;
    busy = (state_q == SRI_XFER) || (!mst && en && (edge_q != 5'h00 || (!clock_phase && !ss_n_in)));
    wr_ok = !tc_q || arm_tc_q; // R11
    start = data_wr && wr_ok && !busy && en && mst; // R15
    fault = en && mst && !ss_n_in && !dir_q[SRI_D_SS];
    restart = start;
    state_d = state_q;
    sh_d = sh_q;
    rxbuf_d = rxbuf_q;
    edge_d = edge_q;
    smp_d = smp_q;
    out_d = out_q;
    sck_d = sck_q;
    done = 1'b0;
    if (!en || fault) begin
      state_d = SRI_IDLE; // R1
      edge_d = 5'h00;
      sck_d = clock_polarity;
    end else if (start) begin
      state_d = SRI_XFER;
      sh_d = wdata;
      edge_d = 5'h00;
      sck_d = clock_polarity;
      out_d = wdata[7];
    end else begin
      if (data_wr && wr_ok && !busy) begin
        sh_d = wdata;
        out_d = wdata[7];
      end
      if (state_q == SRI_IDLE) begin
        sck_d = clock_polarity; // R4
      end else if (tick) begin
        sck_d = !sck_q;
      end
      if (sample_ev) begin
        smp_d = din;
        sh_d = {sh_q[6:0], din}; // R20
      end
      if (drive_ev) begin
        out_d = sh_q[7];
      end
      if (edge_ev) begin
        edge_d = edge_q + 5'h01;
        if (edge_q == SRI_EDGES - 5'h01) begin
          done = 1'b1; // R20
          edge_d = 5'h00;
          state_d = SRI_IDLE;
          rxbuf_d = sh_d; // R16
        end
      end
      // phase 0 slave restarts its byte count while deselected
      if (!mst && !clock_phase && ss_n_in) begin
        edge_d = 5'h00; // R21
      end
      if (!mst && edge_q == 5'h00 && !edge_ev && !(data_wr && wr_ok && !busy)) begin
        out_d = sh_q[7];
      end
    end
  end

  // flags and registers
  always_comb begin
    ctrl_d = ctrl_q;
    dir_d = dir_q;
    tc_d = tc_q;
    write_collision_flag_d = write_collision_flag_q;
    mode_fault_flag_d = mode_fault_flag_q;
    arm_tc_d = arm_tc_q;
    arm_write_collision_flag_d = arm_write_collision_flag_q;
    arm_mode_fault_flag_d = arm_mode_fault_flag_q;
    if (ctrl_wr) begin
      ctrl_d = wdata;
    end
    if (wr && addr == SRI_OFS_DIR) begin
      dir_d = wdata[3:0];
    end
    if (stat_rd) begin
      arm_tc_d = arm_tc_q || tc_q;
      arm_write_collision_flag_d = arm_write_collision_flag_q || write_collision_flag_q;
      arm_mode_fault_flag_d = arm_mode_fault_flag_q || mode_fault_flag_q;
    end
    if (data_acc && arm_tc_q) begin
      tc_d = 1'b0; // R10
      arm_tc_d = 1'b0;
    end
    if (data_acc && arm_write_collision_flag_q) begin
      write_collision_flag_d = 1'b0; // R12
      arm_write_collision_flag_d = 1'b0;
    end
    if (ctrl_wr && arm_mode_fault_flag_q) begin
      mode_fault_flag_d = 1'b0; // R13
      arm_mode_fault_flag_d = 1'b0;
    end
    // sets win over clears
    if (done) begin
      tc_d = 1'b1; // R8
    end
    if (data_wr && wr_ok && busy && en) begin
      write_collision_flag_d = 1'b1; // R19
    end
    if (fault) begin
      mode_fault_flag_d = 1'b1; // R18
      ctrl_d[SRI_C_MASTER] = 1'b0; // R18
      dir_d = 4'h0; // R18
    end
  end

  // read port and interrupt
  always_comb begin
    rdata_d = 8'h00;
    if (rd) begin
      unique case (addr)
        SRI_OFS_CTRL: rdata_d = ctrl_q;
        SRI_OFS_STAT: rdata_d = stat_val;
        SRI_OFS_DATA: rdata_d = rxbuf_q; // R16
        SRI_OFS_DIR: rdata_d = {4'h0, dir_q};
      endcase
    end
    irq_d = tc_d && ctrl_d[SRI_C_IRQ_EN]; // R9
  end

  // pin drivers, open drain drives only the low level
  always_comb begin
    sck_out_d = od ? 1'b0 : sck_d; // R2
    sck_oe_d = en && ctrl_d[SRI_C_MASTER] && dir_d[SRI_D_SCK] && (!od || !sck_d); // R2
    mosi_out_d = od ? 1'b0 : out_d; // R2
    mosi_oe_d = en && ctrl_d[SRI_C_MASTER] && dir_d[SRI_D_MOSI] && (!od || !out_d); // R2
    miso_out_d = od ? 1'b0 : out_d; // R2
    miso_oe_d = en && !ctrl_d[SRI_C_MASTER] && !ss_n_in && dir_d[SRI_D_MISO]
                && (!od || !out_d); // R2
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= SRI_CTRL_RESET;
      dir_q <= SRI_DIR_RESET;
      tc_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      arm_tc_q <= 1'b0;
      arm_write_collision_flag_q <= 1'b0;
      arm_mode_fault_flag_q <= 1'b0;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      state_q <= SRI_IDLE;
      sh_q <= 8'h00;
      rxbuf_q <= 8'h00;
      edge_q <= 5'h00;
      smp_q <= 1'b0;
      out_q <= 1'b0;
      sck_q <= 1'b0;
      sck_prev_q <= 1'b0;
      sck_out_q <= 1'b0;
      sck_oe_q <= 1'b0;
      mosi_out_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_out_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      dir_q <= dir_d;
      tc_q <= tc_d;
      write_collision_flag_q <= write_collision_flag_d;
      mode_fault_flag_q <= mode_fault_flag_d;
      arm_tc_q <= arm_tc_d;
      arm_write_collision_flag_q <= arm_write_collision_flag_d;
      arm_mode_fault_flag_q <= arm_mode_fault_flag_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      state_q <= state_d;
      sh_q <= sh_d;
      rxbuf_q <= rxbuf_d;
      edge_q <= edge_d;
      smp_q <= smp_d;
      out_q <= out_d;
      sck_q <= sck_d;
      sck_prev_q <= sck_in;
      sck_out_q <= sck_out_d;
      sck_oe_q <= sck_oe_d;
      mosi_out_q <= mosi_out_d;
      mosi_oe_q <= mosi_oe_d;
      miso_out_q <= miso_out_d;
      miso_oe_q <= miso_oe_d;
    end
  end

  assign rdata = rdata_q;
  assign irq = irq_q;
  assign sck_out = sck_out_q;
  assign sck_oe = sck_oe_q;
  assign mosi_out = mosi_out_q;
  assign mosi_oe = mosi_oe_q;
  assign miso_out = miso_out_q;
  assign miso_oe = miso_oe_q;
endmodule : sri_core
`default_nettype wire

/* dv/sri_core_asserts.sv */
// port assertions for the serial interface core
`timescale 1ns/1ps
`default_nettype none
module sri_core_chk
  import sri_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [SRI_AW-1:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_n_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00) else $error("stray rdata");
  a_stat_unused: assert property ($past(rd) && $past(addr) == SRI_OFS_STAT |->
    (rdata & 8'h2f) == 8'h00) else $error("unused status bit");
  a_role_excl: assert property (!(mosi_oe && miso_oe)) else $error("both roles drive");
  a_slave_noclk: assert property (miso_oe |-> !sck_oe) else $error("slave drives clock");
  // assumes the select pin is not set as an output
  a_fault_drop: assert property (mosi_oe && !ss_n_in |-> ##[1:4] !mosi_oe && !sck_oe)
    else $error("fault kept drivers");
  a_irq_fall: assert property ($fell(irq) |-> $past(rd || wr) || $past(rd || wr, 2))
    else $error("irq fell alone");
  a_irq_hold: assert property (irq && !(rd || wr) && !$past(rd || wr) |=> irq)
    else $error("irq lost");
  a_miso_sel: assert property (miso_oe |-> !$past(ss_n_in)) else $error("miso unselected");
  c_irq: cover property ($rose(irq));
  c_fault: cover property (mosi_oe && !ss_n_in);
  c_slave: cover property (miso_oe);
endmodule : sri_core_chk
bind sri_core sri_core_chk chk_u (.*);
`default_nettype wire

/* dv/sri_peer.sv */
// remote serial slave, polarity 0 phase 0
`timescale 1ns/1ps
`default_nettype none
module sri_peer (
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] got
);
  logic [7:0] sh = 8'h00;
  initial got = 8'h00;
  always @(negedge ss_n) sh <= tx;
  always @(posedge sck) if (!ss_n) got <= {got[6:0], mosi};
  always @(negedge sck) if (!ss_n) sh <= {sh[6:0], 1'b0};
  assign miso = ss_n ? ~sh[7] : sh[7];
endmodule : sri_peer
`default_nettype wire

/* dv/tb_sri_core.sv */
// self-checking bench for the serial interface core
`timescale 1ns/1ps
`default_nettype none
module tb_sri_core;
  import sri_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, ss_n = 1, pss_n = 1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, ptx = 8'h00, rdata, pgot;
  logic irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, pmiso;
  wire logic sck_w = sck_oe ? sck_out : 1'b0;
  wire logic mosi_w = mosi_oe ? mosi_out : 1'b0;
  wire logic miso_w = miso_oe ? miso_out : pmiso;
  int err_total = 0, cmp_count = 0, n, h;
  initial forever #4 clk = ~clk;
  sri_core dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n));
  sri_peer peer_u (.sck(sck_w), .mosi(mosi_w), .ss_n(pss_n), .tx(ptx), .miso(pmiso),
    .got(pgot));
  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rreg
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wreg(SRI_OFS_DIR, 8'h06);
    for (int r = 0; r < 4; r++) begin
      h = (r < 2) ? (1 << r) : (2 << r);
      ptx <= 8'h5a ^ 8'(r);
      pss_n <= 1'b0;
      wreg(SRI_OFS_CTRL, 8'hd0 | 8'(r));
      wreg(SRI_OFS_DATA, 8'h3c + 8'(r));
      if (r == 0) wreg(SRI_OFS_DATA, 8'hff);
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n++;
      end
      if (n >= 3000) begin
        err_total++;
        $display("[ERR] %0t no completion", $time);
        end_sim;
      end
      chk(8'(n >= 16 * h && n <= 16 * h + 6), 8'h01);
      wreg(SRI_OFS_DATA, 8'h77);
      rreg(SRI_OFS_STAT, (r == 0) ? 8'hc0 : 8'h80);
      rreg(SRI_OFS_DATA, 8'h5a ^ 8'(r));
      rreg(SRI_OFS_STAT, 8'h00);
      chk({7'h00, irq}, 8'h00);
      repeat (600) @(posedge clk);
      chk(pgot, 8'h3c + 8'(r));
      pss_n <= 1'b1;
      @(posedge clk);
    end
    wreg(SRI_OFS_CTRL, 8'h93);
    wreg(SRI_OFS_DATA, 8'h11);
    repeat (100) @(posedge clk);
    rreg(SRI_OFS_STAT, 8'h00);
    wreg(SRI_OFS_CTRL, 8'hd3);
    ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    rreg(SRI_OFS_STAT, 8'h10);
    rreg(SRI_OFS_CTRL, 8'hc3);
    rreg(SRI_OFS_DIR, 8'h00);
    ss_n <= 1'b1;
    wreg(SRI_OFS_CTRL, 8'hc0);
    rreg(SRI_OFS_STAT, 8'h00);
    wreg(SRI_OFS_DIR, 8'h01);
    ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk({6'h00, miso_oe, miso_out}, 8'h02);
    ss_n <= 1'b1;
    rreg(SRI_OFS_STAT, 8'h00);
    wreg(SRI_OFS_DIR, 8'h06);
    wreg(SRI_OFS_CTRL, 8'hd8);
    repeat (3) @(posedge clk);
    chk({6'h00, sck_oe, sck_out}, 8'h03);
    wreg(SRI_OFS_CTRL, 8'hf8);
    repeat (3) @(posedge clk);
    chk({6'h00, sck_oe, sck_out}, 8'h00);
    end_sim;
  end
endmodule : tb_sri_core
`default_nettype wire
